// file: sivm_params.svh
`ifndef SIVM_PARAMS_SVH
`define SIVM_PARAMS_SVH
// register word indices; byte address is four times the index
`define SIVM_IDX_WORD0 4'h0
`define SIVM_IDX_WORD1 4'h1
`define SIVM_IDX_WORD2 4'h2
`define SIVM_IDX_WORD3 4'h3
// vector layout
`define SIVM_VEC_WIDTH 128
`define SIVM_FB_LSB 64
`define SIVM_FB_WIDTH 32
`define SIVM_IN_LSB 96
`define SIVM_AUX_LSB 106
`define SIVM_AUX_WIDTH 22
`define SIVM_VEC_RESET 128'h0
`define SIVM_WORD_RESET 32'h0
`define SIVM_UNMAPPED_READ 32'h0
`endif

// file: sivm_pkg.sv
package sivm_pkg;
   // settled dual channel levels, 1 = 24 V
   typedef struct packed {
      logic [3:0] dualChannelA;
      logic [3:0] dualChannelB;
      logic [3:0] antivalentCfg;
   } sivm_dual_s;
   // settled single and selector levels, 1 = 24 V
   typedef struct packed {
      logic singleInput4;
      logic selectorInputA;
      logic selectorInputB;
      logic selectorInputC;
      logic singleInput8;
      logic singleInput9;
   } sivm_single_s;
   typedef struct packed {
      logic [9:0] safeInBits;
   } sivm_map_s;
   typedef enum logic [0:0] {
      SIVM_IDLE = 1'b0,
      SIVM_RDATA = 1'b1
   } sivm_bus_e;
endpackage : sivm_pkg

// file: sivm_snapshot_mem.sv
`include "sivm_params.svh"
// four word store written in one cycle, registered read
module sivm_snapshot_mem #(
   parameter int WORDS = 4
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic captureEn,
   input wire logic [WORDS*32-1:0] captureVec,
   input wire logic [1:0] readIdx,
   output logic [31:0] readData
);
   logic [31:0] mem [WORDS];

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < WORDS; i++)
         begin
            mem[i] <= `SIVM_WORD_RESET;
         end
         readData <= `SIVM_WORD_RESET;
      end
      else
      begin
         if (captureEn)
         begin
            for (int i = 0; i < WORDS; i++)
            begin
               mem[i] <= captureVec[i*32 +: 32];
            end
         end
         readData <= mem[readIdx];
      end
   end
endmodule : sivm_snapshot_mem

// file: sivm_vector_mapper.sv
// Chosen here: the register addresses and the plain strobed port.
`include "sivm_params.svh"
module sivm_vector_mapper (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire sivm_pkg::sivm_dual_s dualIn,
   input wire sivm_pkg::sivm_single_s singleIn,
   input wire logic settledValid,
   input wire logic [`SIVM_FB_WIDTH-1:0] virtualOutputSignal,
   input wire logic [`SIVM_AUX_WIDTH-1:0] auxStatus,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [`SIVM_VEC_WIDTH-1:0] logicVector,
   output logic [31:0] regRdata
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [`SIVM_VEC_WIDTH-1:0] vec;
      logic [1:0] rdIdx;
      logic rdMapped;
      sivm_pkg::sivm_bus_e bus;
      logic [31:0] rdata;
   } sivm_state_s;

   sivm_state_s state_reg;
   sivm_state_s state_next;
   sivm_pkg::sivm_map_s mapBits;
   logic [31:0] memData;

   // ---------------------------------------------------------------
   // mapping helpers
   // ---------------------------------------------------------------
   function automatic logic dual_map(input logic chA, input logic chB, input logic anti);
      // idle current: asserted when the pair sits in its safe state
      return anti ? (!chA && chB) : (!chA && !chB);
   endfunction : dual_map

   function automatic logic one_of_three(input logic me, input logic o1, input logic o2);
      return me && !o1 && !o2;
   endfunction : one_of_three

   always_comb
   begin
      mapBits = '0;
      for (int i = 0; i < 4; i++)
      begin
         mapBits.safeInBits[i] = dual_map(dualIn.dualChannelA[i], dualIn.dualChannelB[i],
                                          dualIn.antivalentCfg[i]);
      end
      mapBits.safeInBits[4] = singleIn.singleInput4;
      mapBits.safeInBits[5] = one_of_three(singleIn.selectorInputA, singleIn.selectorInputB,
                                           singleIn.selectorInputC);
      mapBits.safeInBits[6] = one_of_three(singleIn.selectorInputB, singleIn.selectorInputA,
                                           singleIn.selectorInputC);
      mapBits.safeInBits[7] = one_of_three(singleIn.selectorInputC, singleIn.selectorInputA,
                                           singleIn.selectorInputB);
      mapBits.safeInBits[8] = singleIn.singleInput8;
      mapBits.safeInBits[9] = singleIn.singleInput9;
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      if (settledValid)
      begin
         state_next.vec[`SIVM_FB_LSB-1:0] = '0;
         state_next.vec[`SIVM_FB_LSB +: `SIVM_FB_WIDTH] = virtualOutputSignal;
         state_next.vec[`SIVM_IN_LSB +: 10] = mapBits.safeInBits;
         state_next.vec[`SIVM_AUX_LSB +: `SIVM_AUX_WIDTH] = auxStatus;
      end
      state_next.bus = sivm_pkg::SIVM_IDLE;
      state_next.rdata = `SIVM_UNMAPPED_READ;
      if (regRead)
      begin
         state_next.bus = sivm_pkg::SIVM_RDATA;
         state_next.rdIdx = regAddr[1:0];
         state_next.rdMapped = (regAddr <= `SIVM_IDX_WORD3);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= '{vec: `SIVM_VEC_RESET, rdIdx: 2'h0, rdMapped: 1'b0,
                        bus: sivm_pkg::SIVM_IDLE, rdata: 32'h0};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // readout
   // ---------------------------------------------------------------
   // whole vector captured in one cycle
   sivm_snapshot_mem #(
      .WORDS(4)
   ) u_snap (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .captureEn(settledValid),
      .captureVec(state_next.vec),
      .readIdx(regAddr[1:0]),
      .readData(memData)
   );

   // word select, zero when not mapped or idle
   always_comb
   begin
      regRdata = (state_reg.bus == sivm_pkg::SIVM_RDATA && state_reg.rdMapped)
                 ? memData : `SIVM_UNMAPPED_READ;
   end

   assign logicVector = state_reg.vec;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      logicVector[63:0] == 64'h0) else $error("reserved bits not zero");

   a_fb_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
      settledValid |=> logicVector[95:64] == $past(virtualOutputSignal))
      else $error("feedback bits mismatch");

   a_dual_equiv: assert property (@(posedge sys_clk) disable iff (!rst_n)
      settledValid && !dualIn.antivalentCfg[0] |=>
      logicVector[96] == ($past(!dualIn.dualChannelA[0] && !dualIn.dualChannelB[0])))
      else $error("equivalent dual bit wrong");

   a_dual_anti: assert property (@(posedge sys_clk) disable iff (!rst_n)
      settledValid && dualIn.antivalentCfg[1] |=>
      logicVector[97] == ($past(!dualIn.dualChannelA[1] && dualIn.dualChannelB[1])))
      else $error("antivalent dual bit wrong");

   a_single_four: assert property (@(posedge sys_clk) disable iff (!rst_n)
      settledValid |=> logicVector[100] == $past(singleIn.singleInput4))
      else $error("bit 100 wrong");

   a_selector_excl: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $countones(logicVector[103:101]) <= 1) else $error("selector not one of three");

   a_selector_b: assert property (@(posedge sys_clk) disable iff (!rst_n)
      settledValid && singleIn.selectorInputA |=> !logicVector[102])
      else $error("bit 102 set with a high");

   a_selector_c: assert property (@(posedge sys_clk) disable iff (!rst_n)
      settledValid && singleIn.selectorInputC && !singleIn.selectorInputA
      && !singleIn.selectorInputB |=> logicVector[103]) else $error("bit 103 not set");

   a_singles_hi: assert property (@(posedge sys_clk) disable iff (!rst_n)
      settledValid |=> logicVector[105:104] ==
      {$past(singleIn.singleInput9), $past(singleIn.singleInput8)})
      else $error("bits 104 105 wrong");

   a_hold_unsettled: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !settledValid |=> $stable(logicVector)) else $error("vector moved unsettled");

   a_read_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
      regRead && regAddr == 4'h2 && !settledValid |=> regRdata == logicVector[95:64])
      else $error("word 2 readout wrong");

   a_idle_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !regRead |=> regRdata == 32'h0) else $error("read data outside read slot");
endmodule : sivm_vector_mapper

// file: sivm_switch_model.sv
// switches and sensors; settled once levels hold for two cycles
module sivm_switch_model (
   input wire logic sys_clk,
   input wire logic [11:0] pinLevels,
   input wire logic [5:0] pinSingle,
   input wire logic freeze,
   output sivm_pkg::sivm_dual_s dualIn,
   output sivm_pkg::sivm_single_s singleIn,
   output logic settledValid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] prevLvl = 18'h0;
   logic [1:0] stableCnt = 2'h0;
   // levels show at once, before they are settled
   assign dualIn = pinLevels;
   assign singleIn = pinSingle;
   // a level change drops settled at once, so no unsettled level is ever taken
   assign settledValid = (stableCnt == 2'h2) && !freeze && ({pinLevels, pinSingle} == prevLvl);
   always @(posedge sys_clk)
   begin
      prevLvl <= {pinLevels, pinSingle};
      if ({pinLevels, pinSingle} != prevLvl)
         stableCnt <= 2'h0;
      else if (stableCnt != 2'h2)
         stableCnt <= stableCnt + 2'h1;
   end
endmodule : sivm_switch_model

// file: safety_input_vector_mapper_tb.sv
module safety_input_vector_mapper_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [11:0] dual; logic [5:0] sgl; logic [9:0] exp;} sivm_row_s;
   sivm_row_s rows [7] = '{'{12'h000, 6'h00, 10'h00F}, '{12'hFF0, 6'h30, 10'h030},
      '{12'h0FF, 6'h08, 10'h04F}, '{12'h5A3, 6'h04, 10'h082}, '{12'h300, 6'h18, 10'h00C},
      '{12'h00F, 6'h03, 10'h300}, '{12'hFF0, 6'h1C, 10'h000}};
   logic sys_clk, rst_n, freeze, settledValid, regWrite, regRead;
   logic [11:0] pinLevels;
   logic [5:0] pinSingle;
   sivm_pkg::sivm_dual_s dualIn;
   sivm_pkg::sivm_single_s singleIn;
   logic [31:0] virtualOutputSignal, regWdata, regRdata;
   logic [21:0] auxStatus;
   logic [3:0] regAddr;
   logic [127:0] logicVector, expV, oldV;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   sivm_switch_model sw_u (.sys_clk(sys_clk), .pinLevels(pinLevels), .pinSingle(pinSingle),
      .freeze(freeze), .dualIn(dualIn), .singleIn(singleIn), .settledValid(settledValid));
   sivm_vector_mapper dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .dualIn(dualIn),
      .singleIn(singleIn), .settledValid(settledValid),
      .virtualOutputSignal(virtualOutputSignal), .auxStatus(auxStatus), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .logicVector(logicVector), .regRdata(regRdata));
   initial sys_clk = 1'b0;
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         print_verdict();
      end
   end
   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic print_verdict();
      if (num_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // one-cycle read strobe, data stands in the next cycle only
   task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
      @(posedge sys_clk);
      regAddr <= idx;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1 check("regRdata", {96'h0, exp}, {96'h0, regRdata});
   endtask : rd
   task automatic ld(input int i);
      @(posedge sys_clk);
      pinLevels <= rows[i].dual;
      pinSingle <= rows[i].sgl;
      virtualOutputSignal <= 32'hC3A50000 | 32'(i);
      auxStatus <= 22'h2A5A5 ^ 22'(i * 3);
      expV = {22'h2A5A5 ^ 22'(i * 3), rows[i].exp, 32'hC3A50000 | 32'(i), 64'h0};
      repeat (6) @(posedge sys_clk);
      #1;
   endtask : ld
   // ------------------------------
   // main sequence
   // ------------------------------
   initial
   begin
      rst_n = 1'b0;
      freeze = 1'b0;
      pinLevels = 12'hFF0;
      pinSingle = 6'h00;
      virtualOutputSignal = 32'h0;
      auxStatus = 22'h0;
      regAddr = 4'h0;
      regWdata = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         ld(i);
         check("logicVector", expV, logicVector);
         for (int w = 0; w < 4; w++)
            rd(4'(w), expV[w*32 +: 32]);
      end
      @(posedge sys_clk);
      #1 check("regRdata idle", 128'h0, {96'h0, regRdata});
      rd(4'h4, 32'h0);
      rd(4'hF, 32'h0);
      @(posedge sys_clk);
      regAddr <= 4'h3;
      regWdata <= 32'hFFFFFFFF;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      rd(4'h3, expV[127:96]);
      oldV = expV;
      freeze <= 1'b1;
      ld(2);
      check("logicVector held", oldV, logicVector);
      freeze <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1 check("logicVector settled", expV, logicVector);
      rst_n <= 1'b0;
      @(posedge sys_clk);
      #1 check("logicVector reset", 128'h0, logicVector);
      check("regRdata reset", 128'h0, {96'h0, regRdata});
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 check("logicVector after reset", expV, logicVector);
      rd(4'h2, expV[95:64]);
      print_verdict();
   end
endmodule : safety_input_vector_mapper_tb
